// File: rtl/port_role_cfg.svh
// constants for the port role and test mode register bank
//
// Functional notes
// - role field: 0 none, 1 host, 2 device
// - cdp status bit: 0 seen, 1 not
// - writing forced L0 bit forces HS L0
// - clearing bit keeps forced state until reset
// - variant id in low bits, not writable; re-latched from strap after soft reset
// - SoC selects role; device adopts, reports it
// - third pin may serve as interrupt
// - pin select: 0 interrupt, 1 charger detected
// - after reset and ready delay, accept requests
`ifndef PORT_ROLE_CFG_SVH
`define PORT_ROLE_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_PORT_ROLE    8'h60
`define ADDR_TX_SWING     8'h70
`define ADDR_TX_PREEMPH   8'h71
`define ADDR_RX_EQ        8'h72
`define ADDR_DISC_SQ      8'h73
`define ADDR_TEST         8'hF5

// ----------------------------------------
// field codes and reset values
// ----------------------------------------
`define ROLE_NONE         2'h0
`define ROLE_HOST         2'h1
`define ROLE_DEVICE       2'h2
`define ROLE_RSVD         2'h3
`define TEST_RSVD_RESET   4'h3
`define TUNE_RESET        8'h00
`define BYTE_ZERO         8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS     10
`define READY_TIME_NS     1000
`define READY_CYCLES      ((`READY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_CNT_W       8

`endif

// File: rtl/port_role_pkg.sv
// types shared by the port role and test mode register bank
`default_nettype none
package port_role_pkg;
    typedef logic [1:0] port_role_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] tx_swing;
        logic [7:0] tx_preemph;
        logic [7:0] rx_eq;
        logic [7:0] disc_sq;
    } tuning_t;

    typedef enum logic {
        ST_WAIT,
        ST_READY
    } ready_state_t;
endpackage : port_role_pkg
`default_nettype wire

// File: rtl/ready_timer.sv
// ready delay timer after hard or soft reset
`default_nettype none
`include "port_role_cfg.svh"
module ready_timer (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      ready
);
    import port_role_pkg::*;

    ready_state_t             state_r;
    ready_state_t             state_nxt;
    logic [`READY_CNT_W-1:0]  cnt_r;
    logic [`READY_CNT_W-1:0]  cnt_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (restart) begin
            state_nxt = ST_WAIT;
            cnt_nxt   = '0;
        end else begin
            unique case (state_r)
                ST_WAIT: begin
                    if (cnt_r == `READY_CNT_W'(`READY_CYCLES - 1)) begin
                        state_nxt = ST_READY;
                    end else begin
                        cnt_nxt = cnt_r + `READY_CNT_W'(1);
                    end
                end
                ST_READY: begin
                    cnt_nxt = cnt_r;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_WAIT;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign ready = (state_r == ST_READY);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    ready_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        restart |=> !ready ##1 !ready)
        else $error("ready seen too soon after restart");
endmodule : ready_timer
`default_nettype wire

// File: rtl/port_role_test_regs.sv
// port role status, test override and phy tuning registers
`default_nettype none
`include "port_role_cfg.svh"
module port_role_test_regs (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire port_role_pkg::reg_req_t  reg_req,
    output logic [7:0]                    reg_rdata,
    output logic                          reg_rvalid,
    input  wire logic                     role_host_req,
    input  wire logic                     role_device_req,
    input  wire logic                     cdp_secondary_enable,
    input  wire logic                     cdp_primary_seen,
    input  wire logic                     soft_reset,
    input  wire logic [2:0]               variant_strap,
    input  wire logic                     i2c_mode,
    input  wire logic                     pin_function_sel,
    input  wire logic                     int_request,
    input  wire logic                     charger_detect,
    output port_role_pkg::tuning_t        tuning,
    output logic                          forced_l0,
    output logic                          link_ready,
    output logic                          third_general_pin_o,
    output logic                          third_general_pin_oe
);
    import port_role_pkg::*;

    port_role_t  role_r;
    port_role_t  role_nxt;
    logic        cdp_r;
    logic        cdp_nxt;
    tuning_t     tune_r;
    tuning_t     tune_nxt;
    logic [3:0]  test_rsvd_r;
    logic [3:0]  test_rsvd_nxt;
    logic        force_bit_r;
    logic        force_bit_nxt;
    logic        forced_r;
    logic        forced_nxt;
    logic [2:0]  variant_r;
    logic [2:0]  variant_nxt;
    logic        var_cap_r;
    logic        var_cap_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic        pin_o_r;
    logic        pin_o_nxt;
    logic        pin_oe_r;
    logic        pin_oe_nxt;
    logic        ready_w;
    logic        wr_ok;
    logic        rd_ok;

    // ----------------------------------------
    // ready delay
    // ----------------------------------------
    ready_timer u_ready_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .restart (soft_reset),
        .ready   (ready_w)
    );

    assign wr_ok = reg_req.wr & ready_w & ~soft_reset;
    assign rd_ok = reg_req.rd & ready_w & ~soft_reset;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    always_comb begin
        role_nxt      = role_r;
        cdp_nxt       = cdp_r;
        tune_nxt      = tune_r;
        test_rsvd_nxt = test_rsvd_r;
        force_bit_nxt = force_bit_r;
        forced_nxt    = forced_r;
        variant_nxt   = variant_r;
        var_cap_nxt   = var_cap_r;
        rdata_nxt     = rdata_r;
        rvalid_nxt    = rd_ok;
        if (soft_reset) begin
            role_nxt      = `ROLE_NONE;
            cdp_nxt       = 1'b0;
            tune_nxt      = {4{`TUNE_RESET}};
            test_rsvd_nxt = `TEST_RSVD_RESET;
            force_bit_nxt = 1'b0;
            forced_nxt    = 1'b0;
            var_cap_nxt   = 1'b0;
        end else begin
            // role chosen by the SoC, host wins a tie
            if (ready_w && role_host_req) begin
                role_nxt = `ROLE_HOST;
            end else if (ready_w && role_device_req) begin
                role_nxt = `ROLE_DEVICE;
            end
            cdp_nxt = cdp_secondary_enable & ~cdp_primary_seen;
            if (!var_cap_r) begin
                variant_nxt = variant_strap;
                var_cap_nxt = 1'b1;
            end
            if (wr_ok) begin
                unique case (reg_req.addr)
                    `ADDR_TX_SWING:   tune_nxt.tx_swing   = reg_req.wdata;
                    `ADDR_TX_PREEMPH: tune_nxt.tx_preemph = reg_req.wdata;
                    `ADDR_RX_EQ:      tune_nxt.rx_eq      = reg_req.wdata;
                    `ADDR_DISC_SQ:    tune_nxt.disc_sq    = reg_req.wdata;
                    `ADDR_TEST: begin
                        test_rsvd_nxt = reg_req.wdata[7:4];
                        force_bit_nxt = reg_req.wdata[3];
                        if (reg_req.wdata[3]) begin
                            forced_nxt = 1'b1;
                        end
                    end
                    default: begin
                        tune_nxt = tune_r;
                    end
                endcase
            end
            if (rd_ok) begin
                unique case (reg_req.addr)
                    `ADDR_PORT_ROLE:  rdata_nxt = {3'h0, role_r, 2'h0, cdp_r};
                    `ADDR_TX_SWING:   rdata_nxt = tune_r.tx_swing;
                    `ADDR_TX_PREEMPH: rdata_nxt = tune_r.tx_preemph;
                    `ADDR_RX_EQ:      rdata_nxt = tune_r.rx_eq;
                    `ADDR_DISC_SQ:    rdata_nxt = tune_r.disc_sq;
                    `ADDR_TEST:       rdata_nxt = {test_rsvd_r, force_bit_r, variant_r};
                    default:          rdata_nxt = `BYTE_ZERO;
                endcase
            end
        end
    end

    // ----------------------------------------
    // third pin function
    // ----------------------------------------
    always_comb begin
        pin_o_nxt  = 1'b0;
        pin_oe_nxt = 1'b0;
        if (i2c_mode) begin
            if (pin_function_sel) begin
                pin_o_nxt  = charger_detect;
                pin_oe_nxt = 1'b1;
            end else begin
                pin_oe_nxt = int_request;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            role_r      <= `ROLE_NONE;
            cdp_r       <= 1'b0;
            tune_r      <= {4{`TUNE_RESET}};
            test_rsvd_r <= `TEST_RSVD_RESET;
            force_bit_r <= 1'b0;
            forced_r    <= 1'b0;
            variant_r   <= 3'h0;
            var_cap_r   <= 1'b0;
            rdata_r     <= `BYTE_ZERO;
            rvalid_r    <= 1'b0;
            pin_o_r     <= 1'b0;
            pin_oe_r    <= 1'b0;
        end else begin
            role_r      <= role_nxt;
            cdp_r       <= cdp_nxt;
            tune_r      <= tune_nxt;
            test_rsvd_r <= test_rsvd_nxt;
            force_bit_r <= force_bit_nxt;
            forced_r    <= forced_nxt;
            variant_r   <= variant_nxt;
            var_cap_r   <= var_cap_nxt;
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
            pin_o_r     <= pin_o_nxt;
            pin_oe_r    <= pin_oe_nxt;
        end
    end

    assign reg_rdata            = rdata_r;
    assign reg_rvalid           = rvalid_r;
    assign tuning               = tune_r;
    assign forced_l0            = forced_r;
    assign link_ready           = ready_w;
    assign third_general_pin_o  = pin_o_r;
    assign third_general_pin_oe = pin_oe_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    role_never_rsvd_a: assert property (role_r != `ROLE_RSVD)
        else $error("reserved role code reported");
    role_host_adopt_a: assert property (
        ready_w && role_host_req && !soft_reset |=> role_r == `ROLE_HOST)
        else $error("host role not adopted");
    role_dev_adopt_a: assert property (
        ready_w && role_device_req && !role_host_req && !soft_reset
        |=> role_r == `ROLE_DEVICE)
        else $error("device role not adopted");
    cdp_status_a: assert property (
        cdp_secondary_enable && !soft_reset |=> cdp_r == !$past(cdp_primary_seen))
        else $error("cdp status bit wrong");
    force_set_a: assert property (
        wr_ok && reg_req.addr == `ADDR_TEST && reg_req.wdata[3] |=> forced_l0 ##1 forced_l0
        or soft_reset)
        else $error("forced L0 not entered");
    force_hold_a: assert property (
        forced_l0 && !soft_reset |=> forced_l0)
        else $error("forced L0 left without reset");
    force_clear_a: assert property (soft_reset |=> !forced_l0 && role_r == `ROLE_NONE)
        else $error("soft reset did not clear state");
    variant_keep_a: assert property (
        var_cap_r && !soft_reset |=> $stable(variant_r))
        else $error("variant id changed");
    cfg_read_a: assert property (
        rd_ok && reg_req.addr == `ADDR_PORT_ROLE
        |=> reg_rvalid && reg_rdata[7:5] == 3'h0 && reg_rdata[2:1] == 2'h0
        && reg_rdata[4:3] == $past(role_r))
        else $error("port role read wrong");
    pin_int_a: assert property (
        i2c_mode && !pin_function_sel
        |=> third_general_pin_oe == $past(int_request) && !third_general_pin_o)
        else $error("interrupt pin drive wrong");
    pin_chg_a: assert property (
        i2c_mode && pin_function_sel
        |=> third_general_pin_oe && third_general_pin_o == $past(charger_detect))
        else $error("charger pin drive wrong");

    host_role_c:   cover property (ready_w && role_host_req ##1 role_r == `ROLE_HOST);
    device_role_c: cover property (ready_w && role_device_req ##1 role_r == `ROLE_DEVICE);
    forced_c:      cover property (forced_l0 && !force_bit_r);
    test_read_c:   cover property (rd_ok && reg_req.addr == `ADDR_TEST ##1 reg_rvalid);
endmodule : port_role_test_regs
`default_nettype wire

// File: dv/soc_host_model.sv
// SoC side model: register requests and port role selection
`default_nettype none
module soc_host_model (
    input  wire logic               ref_clk,
    output port_role_pkg::reg_req_t reg_req,
    output logic                    role_host_req,
    output logic                    role_device_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import port_role_pkg::*;

    initial begin
        reg_req = '0;
        role_host_req = 1'b0;
        role_device_req = 1'b0;
    end

    // ----------------------------------------
    // one byte access, held for exactly one edge
    // ----------------------------------------
    task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
                          input logic [7:0] wdata);
        @(posedge ref_clk);
        reg_req <= {rd, wr, addr, wdata};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask : access

    // ----------------------------------------
    // role selection pulse
    // ----------------------------------------
    task automatic select_role(input logic host, input logic dev);
        @(posedge ref_clk);
        role_host_req <= host;
        role_device_req <= dev;
        @(posedge ref_clk);
        role_host_req <= 1'b0;
        role_device_req <= 1'b0;
    endtask : select_role
endmodule : soc_host_model
`default_nettype wire

// File: dv/tb_port_role_test_regs.sv
// testbench for the port role and test mode register bank
`default_nettype none
`include "port_role_cfg.svh"
module tb_port_role_test_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import port_role_pkg::*;

    logic ref_clk, rst_n, soft_reset, i2c_mode, pin_function_sel, int_request, charger_detect;
    logic cdp_secondary_enable, cdp_primary_seen, role_host_req, role_device_req;
    logic forced_l0, link_ready, third_general_pin_o, third_general_pin_oe, reg_rvalid;
    logic [2:0] variant_strap, var_v;
    logic [7:0] reg_rdata, lfsr_r, k;
    logic [7:0] tune_v [8];
    reg_req_t   reg_req;
    tuning_t    tuning;
    logic [7:0] exp_q [$];
    int         errors, total_checks;

    soc_host_model u_soc_host_model (.ref_clk(ref_clk), .reg_req(reg_req),
        .role_host_req(role_host_req), .role_device_req(role_device_req));

    port_role_test_regs u_port_role_test_regs (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .role_host_req(role_host_req), .role_device_req(role_device_req),
        .cdp_secondary_enable(cdp_secondary_enable), .cdp_primary_seen(cdp_primary_seen),
        .soft_reset(soft_reset), .variant_strap(variant_strap), .i2c_mode(i2c_mode),
        .pin_function_sel(pin_function_sel), .int_request(int_request),
        .charger_detect(charger_detect), .tuning(tuning), .forced_l0(forced_l0),
        .link_ready(link_ready), .third_general_pin_o(third_general_pin_o),
        .third_general_pin_oe(third_general_pin_oe));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr_next

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic give_up;
        errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        print_verdict();
    endtask : give_up

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_soc_host_model.access(1'b1, 1'b0, a, 8'h00);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_soc_host_model.access(1'b0, 1'b1, a, d);
    endtask : wr

    task automatic wait_ready;
        int n;
        n = 0;
        while (link_ready !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300) give_up();
    endtask : wait_ready

    // ----------------------------------------
    // read answer monitor
    // ----------------------------------------
    always @(negedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("CHECK FAILED at %0t: unexpected read answer", $time);
            end else begin
                check(reg_rdata, exp_q.pop_front());
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        lfsr_r = 8'h2F;
        var_v = lfsr_r[2:0];
        rst_n = 1'b0;
        {soft_reset, i2c_mode, pin_function_sel, int_request, charger_detect} = '0;
        {cdp_secondary_enable, cdp_primary_seen} = '0;
        variant_strap = var_v;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check({7'h00, link_ready}, 8'h00);
        u_soc_host_model.access(1'b1, 1'b0, `ADDR_TEST, 8'h00);
        wait_ready();
        rd(`ADDR_PORT_ROLE, 8'h00);
        rd(`ADDR_TEST, {4'h3, 1'b0, var_v});
        rd(8'h10, 8'h00);
        tune_v = '{8'h7C, 8'h3C, 8'h92, 8'h83, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            if (i >= 4) begin
                lfsr_r = lfsr_next(lfsr_r);
                tune_v[i] = lfsr_r;
            end
            wr(`ADDR_TX_SWING + 8'(i % 4), tune_v[i]);
            rd(`ADDR_TX_SWING + 8'(i % 4), tune_v[i]);
            check(tuning[31 - 8 * (i % 4) -: 8], tune_v[i]);
        end
        wr(`ADDR_PORT_ROLE, 8'hFF);
        rd(`ADDR_PORT_ROLE, 8'h00);
        u_soc_host_model.select_role(1'b0, 1'b1);
        rd(`ADDR_PORT_ROLE, 8'h10);
        u_soc_host_model.select_role(1'b1, 1'b0);
        rd(`ADDR_PORT_ROLE, 8'h08);
        u_soc_host_model.select_role(1'b1, 1'b1);
        rd(`ADDR_PORT_ROLE, 8'h08);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            cdp_secondary_enable <= (i != 2);
            cdp_primary_seen <= (i == 1);
            rd(`ADDR_PORT_ROLE, (i == 0) ? 8'h09 : 8'h08);
        end
        wr(`ADDR_TEST, {4'h3, 1'b1, var_v});
        @(negedge ref_clk);
        check({7'h00, forced_l0}, 8'h01);
        rd(`ADDR_TEST, {4'h3, 1'b1, var_v});
        wr(`ADDR_TEST, {4'h3, 1'b0, var_v});
        rd(`ADDR_TEST, {4'h3, 1'b0, var_v});
        check({7'h00, forced_l0}, 8'h01);
        lfsr_r = lfsr_next(lfsr_r);
        var_v = lfsr_r[2:0];
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        variant_strap <= var_v;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        @(negedge ref_clk);
        check({6'h00, forced_l0, link_ready}, 8'h00);
        wr(`ADDR_TX_SWING, 8'h5A);
        u_soc_host_model.select_role(1'b1, 1'b0);
        wait_ready();
        rd(`ADDR_TEST, {4'h3, 1'b0, var_v});
        rd(`ADDR_TX_SWING, 8'h00);
        rd(`ADDR_PORT_ROLE, 8'h00);
        for (int i = 0; i < 8; i++) begin
            k = 8'(i);
            @(posedge ref_clk);
            {i2c_mode, pin_function_sel, int_request} <= k[2:0];
            charger_detect <= k[0];
            @(posedge ref_clk);
            @(negedge ref_clk);
            check({6'h00, third_general_pin_o, third_general_pin_oe},
                  {6'h00, k[2] & k[1] & k[0], k[2] & (k[1] | k[0])});
        end
        for (int n = 0; n < 20 && exp_q.size() != 0; n++) @(negedge ref_clk);
        if (exp_q.size() != 0) give_up();
        print_verdict();
    end
endmodule : tb_port_role_test_regs
`default_nettype wire
